// ### sbsr_ctrl_model.sv
/*
  bus controller model: serial polls the device while srq is high and auto_en is set.
  assumes the one-cycle poll strobe and registered poll answer of the status byte block.
*/
`timescale 1ns/1ps
module sbsr_ctrl_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic auto_en,
  input wire logic srq,
  input wire logic spoll_valid_r,
  input wire logic [7:0] spoll_byte_r,
  output logic spoll_done,
  output logic [7:0] poll_byte
);
  logic busy_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spoll_done <= 1'b0;
      busy_r <= 1'b0;
      poll_byte <= 8'h00;
    end else begin
      spoll_done <= 1'b0;
      // srq tells the controller which device wants service
      if (auto_en && srq && !busy_r) begin
        spoll_done <= 1'b1;
        busy_r <= 1'b1;
      end
      if (spoll_valid_r) begin
        poll_byte <= spoll_byte_r;
        busy_r <= 1'b0;
      end
    end
  end
endmodule

// ### sbsr_pkg.sv
/*
  types shared by the status byte block: event register set selector and queue selector.
  assumes sbsr_regs.svh is on the include path.
*/
package sbsr_pkg;
  // order fixes the index of each set inside the design's arrays
  typedef enum logic [1:0] {
    SET_STD,
    SET_OPER,
    SET_MEAS,
    SET_QUES
  } sbsr_set_type;

  typedef enum logic [0:0] {
    Q_ERR,
    Q_OUT
  } sbsr_queue_type;
endpackage

// ### sbsr_regs.svh
/*
  status byte / service request constants: bit positions, widths, reset values.
  assumes inclusion by bare name from the design file.
*/
`ifndef SBSR_REGS_SVH
`define SBSR_REGS_SVH

// ----------------------------------------------------------------
// status byte bit positions
// ----------------------------------------------------------------
`define SBSR_BIT_MEAS 0
`define SBSR_BIT_UNUSED 1
`define SBSR_BIT_ERR 2
`define SBSR_BIT_QUES 3
`define SBSR_BIT_MAV 4
`define SBSR_BIT_STD 5
`define SBSR_BIT_RQS 6
`define SBSR_BIT_OPER 7

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define SBSR_BYTE_W 8
`define SBSR_EVT_W 16
`define SBSR_STD_W 8
`define SBSR_QDEPTH 16
`define SBSR_NUM_SETS 4
`define SBSR_NUM_QUEUES 2
`define SBSR_MASK_RESET 8'h00
`define SBSR_BYTE_ZERO 8'h00
`define SBSR_RESP_ZERO 16'h0000

`endif

// ### sbsr_sb_assertions.sv
/*
  port checker for the status byte block.
  assumes it is bound onto every sbsr_status_byte instance.
*/
`timescale 1ns/1ps
module sbsr_sb_assertions #(
  parameter int EVT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mask_wr,
  input wire logic [7:0] mask_wdata,
  input wire logic mask_query,
  input wire logic stb_query,
  input wire logic spoll_done,
  input wire logic [EVT_W-1:0] resp_data_r,
  input wire logic resp_valid_r,
  input wire logic [7:0] spoll_byte_r,
  input wire logic spoll_valid_r,
  input wire logic srq,
  input wire logic [7:0] status_summary_byte,
  input wire logic [7:0] request_enable_mask_r,
  input wire logic error_queue_nonempty,
  input wire logic questionable_summary,
  input wire logic standard_event_summary,
  input wire logic operation_summary
);
  logic [7:0] hit;
  // mask bit 6 has no summary behind it
  assign hit = status_summary_byte & request_enable_mask_r & 8'hbf;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_unused_zero: assert property (status_summary_byte[1] == 1'b0)
    else $error("status bit 1 set");
  a_byte_map: assert property ({status_summary_byte[7], status_summary_byte[5], status_summary_byte[3:2]} ==
    {operation_summary, standard_event_summary, questionable_summary, error_queue_nonempty})
    else $error("summary bit map wrong");
  a_mss_level: assert property (status_summary_byte[6] == (|hit))
    else $error("master summary wrong");
  a_rise_sets: assert property ((|(hit & ~$past(hit))) && $stable(request_enable_mask_r) |-> ##[0:1] srq)
    else $error("request not raised");
  a_srq_holds: assert property (srq && !spoll_done |=> srq)
    else $error("request dropped without poll");
  a_poll_answer: assert property (spoll_done |=> spoll_valid_r && spoll_byte_r ==
    (($past(status_summary_byte) & 8'hbf) | {1'b0, $past(srq), 6'h00}))
    else $error("poll byte wrong");
  a_mask_write: assert property (mask_wr |=> request_enable_mask_r == $past(mask_wdata))
    else $error("mask write lost");
  a_mask_kept: assert property (!mask_wr |=> $stable(request_enable_mask_r))
    else $error("mask changed");
  a_stb_answer: assert property (stb_query |=> resp_valid_r && resp_data_r == EVT_W'($past(status_summary_byte)))
    else $error("status query answer wrong");
  a_mask_answer: assert property (mask_query && !stb_query |=>
    resp_valid_r && resp_data_r == EVT_W'($past(request_enable_mask_r)))
    else $error("mask query answer wrong");
  c_srq: cover property ($rose(srq));
  c_poll: cover property (spoll_valid_r && spoll_byte_r[6]);
  c_mss: cover property (resp_valid_r && resp_data_r[6]);
endmodule

bind sbsr_status_byte sbsr_sb_assertions #(.EVT_W(EVT_W)) u_chk (.mclk(mclk), .rst_n(rst_n), .mask_wr(mask_wr),
  .mask_wdata(mask_wdata), .mask_query(mask_query), .stb_query(stb_query), .spoll_done(spoll_done),
  .resp_data_r(resp_data_r), .resp_valid_r(resp_valid_r), .spoll_byte_r(spoll_byte_r),
  .spoll_valid_r(spoll_valid_r), .srq(srq), .status_summary_byte(status_summary_byte),
  .request_enable_mask_r(request_enable_mask_r), .error_queue_nonempty(error_queue_nonempty),
  .questionable_summary(questionable_summary), .standard_event_summary(standard_event_summary),
  .operation_summary(operation_summary));

// ### sbsr_status_byte.sv
/*
  status byte and service request logic of a measurement instrument: four event
  register sets, error and output queue occupancy, status byte, request enable
  mask, request-for-service flag, serial poll answer and the service request line.
  assumes the command parser turns common commands and bus polls into one-cycle
  strobes synchronous to mclk, and that the bus driver turns srq into the wire.
  the event enable registers have no read-back path in this block.
*/
// Notes on behaviour
// - two 8-bit registers: status byte and service request enable mask.
// - summary bits 0,2,3,4,5,7 follow their summary messages, never latched.
// - bit 0 shows enabled measurement event pending; bit 1 reads zero.
// - bit 2 set while the error queue holds a message.
// - bit 3 set while an enabled questionable event is pending.
// - bit 4 set while the output queue holds a response.
// - bit 5 set while an enabled standard event is pending.
// - bit 7 set while an enabled operation event is pending.
// - summary bits AND mask, ORed together, drive bit 6.
// - bit 6 is request flag on serial poll, master summary on query.
// - any enabled summary bit rising sets the request flag and requests service.
// - a completed serial poll clears the request flag.
// - after a poll, a new occurrence of the same event requests again; a new entry into a non-empty output queue does not.
// - poll leaves master summary alone; it holds while any enabled summary bit set.
// - reading the standard event register clears it, dropping bit 5.
// - mask write takes a value 0 to 255 as the eight enable bits.
// - mask query returns the mask; status query returns the status byte.
// - mask clears at power-up or when zero is written.
// - clear-status and status-preset leave the mask unchanged.
// - controller reads the byte by poll sequence, finds requester by srq.
// - with mask 4, an error entering the queue sets bits 2 and 6.
// - each set's summary is OR of latched events ANDed with enables.
// - power-on clears every status register; both queues start empty.
// - each queue raises its summary bit while holding an entry.
`timescale 1ns/1ps
`include "sbsr_regs.svh"

module sbsr_status_byte #(
  parameter int EVT_W = `SBSR_EVT_W,
  parameter int STD_W = `SBSR_STD_W,
  parameter int QDEPTH = `SBSR_QDEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  // event sources, one-cycle pulses per event bit
  input wire logic [STD_W-1:0] std_event_in,
  input wire logic [EVT_W-1:0] oper_event_in,
  input wire logic [EVT_W-1:0] meas_event_in,
  input wire logic [EVT_W-1:0] ques_event_in,
  // event register set access
  input wire sbsr_pkg::sbsr_set_type evt_sel,
  input wire logic evt_en_wr,
  input wire logic [EVT_W-1:0] evt_en_wdata,
  input wire logic evt_rd,
  input wire logic clear_status,
  input wire logic status_preset,
  // queue occupancy
  input wire logic err_push,
  input wire logic err_pop,
  input wire logic err_clear,
  input wire logic out_push,
  input wire logic out_pop,
  // common commands
  input wire logic mask_wr,
  input wire logic [`SBSR_BYTE_W-1:0] mask_wdata,
  input wire logic mask_query,
  input wire logic stb_query,
  output logic [EVT_W-1:0] resp_data_r,
  output logic resp_valid_r,
  // serial poll
  input wire logic spoll_done,
  output logic [`SBSR_BYTE_W-1:0] spoll_byte_r,
  output logic spoll_valid_r,
  output logic srq,
  // status visibility
  output logic [`SBSR_BYTE_W-1:0] status_summary_byte,
  output logic [`SBSR_BYTE_W-1:0] request_enable_mask_r,
  output logic error_queue_nonempty,
  output logic questionable_summary,
  output logic standard_event_summary,
  output logic operation_summary
);

  localparam int CNT_W = $clog2(QDEPTH + 1);
  // standard enable bits above STD_W could never meet an event, so they are not stored
  localparam logic [EVT_W-1:0] STD_KEEP = EVT_W'((1 << STD_W) - 1);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (STD_W < 1 || STD_W > EVT_W) begin : g_bad_std
    $error("standard event width must lie between 1 and the event width");
  end
  if (EVT_W < 1 || EVT_W > 16) begin : g_bad_evt
    $error("event width must lie between 1 and 16");
  end
  if (QDEPTH < 1) begin : g_bad_q
    $error("queue depth must be at least 1");
  end
  // the set and queue arrays are indexed directly by the package's enum codes
  if ((1 << $bits(sbsr_pkg::sbsr_set_type)) != `SBSR_NUM_SETS) begin : g_bad_sets
    $error("every set selector code must name one event register set");
  end
  if ((1 << $bits(sbsr_pkg::sbsr_queue_type)) != `SBSR_NUM_QUEUES) begin : g_bad_queues
    $error("every queue code must name one queue");
  end

  // ----------------------------------------------------------------
  // event register sets
  // ----------------------------------------------------------------
  logic [EVT_W-1:0] evt_in [`SBSR_NUM_SETS];
  logic [EVT_W-1:0] event_r [`SBSR_NUM_SETS];
  logic [EVT_W-1:0] enable_r [`SBSR_NUM_SETS];
  logic [`SBSR_NUM_SETS-1:0] set_summary;
  logic [`SBSR_NUM_SETS-1:0] set_fresh;

  assign evt_in[sbsr_pkg::SET_STD] = EVT_W'(std_event_in);
  assign evt_in[sbsr_pkg::SET_OPER] = oper_event_in;
  assign evt_in[sbsr_pkg::SET_MEAS] = meas_event_in;
  assign evt_in[sbsr_pkg::SET_QUES] = ques_event_in;

  for (genvar s = 0; s < `SBSR_NUM_SETS; s++) begin : g_set
    logic sel_hit;
    assign sel_hit = (evt_sel == sbsr_pkg::sbsr_set_type'(s));

    // an event arriving in the clearing cycle survives the clear
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        event_r[s] <= '0;
      end else if (clear_status || (evt_rd && sel_hit)) begin
        event_r[s] <= evt_in[s];
      end else begin
        event_r[s] <= event_r[s] | evt_in[s];
      end
    end

    // status preset spares the standard event enable
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        enable_r[s] <= '0;
      end else if (evt_en_wr && sel_hit) begin
        if (s == sbsr_pkg::SET_STD) begin
          enable_r[s] <= evt_en_wdata & STD_KEEP;
        end else begin
          enable_r[s] <= evt_en_wdata;
        end
      end else if (status_preset && s != sbsr_pkg::SET_STD) begin
        enable_r[s] <= '0;
      end
    end

    assign set_summary[s] = |(event_r[s] & enable_r[s]);
    // a new enabled occurrence, even onto an already latched bit
    assign set_fresh[s] = |(evt_in[s] & enable_r[s]);
  end

  // ----------------------------------------------------------------
  // queue occupancy
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] qcnt_r [`SBSR_NUM_QUEUES];
  logic [`SBSR_NUM_QUEUES-1:0] q_push;
  logic [`SBSR_NUM_QUEUES-1:0] q_pop;
  logic [`SBSR_NUM_QUEUES-1:0] q_clr;
  logic [`SBSR_NUM_QUEUES-1:0] q_nonempty;

  assign q_push = {out_push, err_push};
  assign q_pop = {out_pop, err_pop};
  // clear-status empties the error queue but never the output queue
  assign q_clr = {1'b0, clear_status | err_clear};

  for (genvar q = 0; q < `SBSR_NUM_QUEUES; q++) begin : g_queue
    logic q_full;
    logic q_empty;
    logic do_push;
    logic do_pop;
    assign q_full = (qcnt_r[q] == CNT_W'(QDEPTH));
    assign q_empty = (qcnt_r[q] == '0);
    // a push into a full queue is dropped, a pop from empty is ignored
    assign do_push = q_push[q] && !q_full;
    assign do_pop = q_pop[q] && !q_empty;

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        qcnt_r[q] <= '0;
      end else if (q_clr[q]) begin
        qcnt_r[q] <= CNT_W'(q_push[q]);
      end else if (do_push && !do_pop) begin
        qcnt_r[q] <= qcnt_r[q] + CNT_W'(1);
      end else if (do_pop && !do_push) begin
        qcnt_r[q] <= qcnt_r[q] - CNT_W'(1);
      end
    end

    assign q_nonempty[q] = !q_empty;
  end

  // ----------------------------------------------------------------
  // status byte
  // ----------------------------------------------------------------
  logic [`SBSR_BYTE_W-1:0] summary_bits;
  logic [`SBSR_BYTE_W-1:0] fresh_bits;
  logic [`SBSR_BYTE_W-1:0] enabled_bits;
  logic [`SBSR_BYTE_W-1:0] enabled_prev_r;
  logic master_summary;

  assign error_queue_nonempty = q_nonempty[sbsr_pkg::Q_ERR];
  assign questionable_summary = set_summary[sbsr_pkg::SET_QUES];
  assign standard_event_summary = set_summary[sbsr_pkg::SET_STD];
  assign operation_summary = set_summary[sbsr_pkg::SET_OPER];

  // summary bits are wires from their sources, nothing latches here
  always_comb begin
    summary_bits = `SBSR_BYTE_ZERO;
    summary_bits[`SBSR_BIT_MEAS] = set_summary[sbsr_pkg::SET_MEAS];
    summary_bits[`SBSR_BIT_UNUSED] = 1'b0;
    summary_bits[`SBSR_BIT_ERR] = error_queue_nonempty;
    summary_bits[`SBSR_BIT_QUES] = questionable_summary;
    summary_bits[`SBSR_BIT_MAV] = q_nonempty[sbsr_pkg::Q_OUT];
    summary_bits[`SBSR_BIT_STD] = standard_event_summary;
    summary_bits[`SBSR_BIT_OPER] = operation_summary;
  end

  always_comb begin
    fresh_bits = `SBSR_BYTE_ZERO;
    fresh_bits[`SBSR_BIT_MEAS] = set_fresh[sbsr_pkg::SET_MEAS];
    fresh_bits[`SBSR_BIT_ERR] = err_push;
    fresh_bits[`SBSR_BIT_QUES] = set_fresh[sbsr_pkg::SET_QUES];
    // an output queue push retriggers only through its summary rising
    fresh_bits[`SBSR_BIT_MAV] = 1'b0;
    fresh_bits[`SBSR_BIT_STD] = set_fresh[sbsr_pkg::SET_STD];
    fresh_bits[`SBSR_BIT_OPER] = set_fresh[sbsr_pkg::SET_OPER];
  end

  // mask bit 6 has no summary bit behind it and so never contributes
  assign enabled_bits = summary_bits & request_enable_mask_r;
  assign master_summary = |enabled_bits;

  always_comb begin
    status_summary_byte = summary_bits;
    status_summary_byte[`SBSR_BIT_RQS] = master_summary;
  end

  // ----------------------------------------------------------------
  // service request enable mask
  // ----------------------------------------------------------------
  // clear-status and preset do not reach this register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      request_enable_mask_r <= `SBSR_MASK_RESET;
    end else if (mask_wr) begin
      request_enable_mask_r <= mask_wdata;
    end
  end

  // ----------------------------------------------------------------
  // request-for-service flag
  // ----------------------------------------------------------------
  logic rqs_r;
  logic rqs_set;
  logic [`SBSR_BYTE_W-1:0] rise_bits;
  logic fresh_hit;

  // zero after reset matches the idle level, so release makes no false rise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enabled_prev_r <= `SBSR_BYTE_ZERO;
    end else begin
      enabled_prev_r <= enabled_bits;
    end
  end

  // a rising enabled summary bit requests service
  assign rise_bits = enabled_bits & ~enabled_prev_r;
  // a fresh enabled occurrence requests again even behind an already latched bit
  assign fresh_hit = |(fresh_bits & request_enable_mask_r);
  assign rqs_set = (|rise_bits) || fresh_hit;

  // a poll that meets a new request in the same cycle leaves the flag set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rqs_r <= 1'b0;
    end else if (rqs_set) begin
      rqs_r <= 1'b1;
    end else if (spoll_done) begin
      rqs_r <= 1'b0;
    end
  end

  // level request straight from the flag; wire timing belongs to the bus driver
  assign srq = rqs_r;

  // ----------------------------------------------------------------
  // serial poll answer
  // ----------------------------------------------------------------
  logic [`SBSR_BYTE_W-1:0] spoll_byte_nxt;

  // the poll byte carries the flag in bit 6, never the master summary
  always_comb begin
    spoll_byte_nxt = summary_bits;
    spoll_byte_nxt[`SBSR_BIT_RQS] = rqs_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spoll_byte_r <= `SBSR_BYTE_ZERO;
    end else if (spoll_done) begin
      spoll_byte_r <= spoll_byte_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spoll_valid_r <= 1'b0;
    end else begin
      spoll_valid_r <= spoll_done;
    end
  end

  // ----------------------------------------------------------------
  // query answers
  // ----------------------------------------------------------------
  // one answer per cycle: status byte first, then mask, then event read
  // a losing query gets no answer of its own, so the parser issues one at a time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_data_r <= '0;
    end else if (stb_query) begin
      resp_data_r <= EVT_W'(status_summary_byte);
    end else if (mask_query) begin
      resp_data_r <= EVT_W'(request_enable_mask_r);
    end else if (evt_rd) begin
      resp_data_r <= event_r[evt_sel];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_r <= 1'b0;
    end else begin
      resp_valid_r <= stb_query | mask_query | evt_rd;
    end
  end

endmodule

// ### sbsr_status_byte_tb.sv
/*
  testbench for the status byte block: command strobes, events, queue counts, polls.
  assumes the one-cycle strobe contract and registered answers of the design.
*/
`timescale 1ns/1ps
module sbsr_status_byte_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] ctl = '0;
  logic [15:0] ev [4] = '{default: '0};
  logic [15:0] en_wdata = '0;
  logic [7:0] mask_wdata = '0;
  logic auto_en = 1'b0;
  sbsr_pkg::sbsr_set_type sel = sbsr_pkg::SET_STD;
  logic [15:0] resp;
  logic rvalid, spoll_done, pvalid, srq, eqn, qs, ses, os;
  logic [7:0] pbyte, ssb, mask, poll_byte, expv;
  logic [7:0] bitv [3] = '{8'h80, 8'h01, 8'h08};
  int n_errors = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // design and controller
  // ----------------------------------------------------------------
  sbsr_status_byte dut (.mclk(mclk), .rst_n(rst_n), .std_event_in(ev[0][7:0]), .oper_event_in(ev[1]),
    .meas_event_in(ev[2]), .ques_event_in(ev[3]), .evt_sel(sel), .evt_en_wr(ctl[8]), .evt_en_wdata(en_wdata),
    .evt_rd(ctl[9]), .clear_status(ctl[10]), .status_preset(ctl[11]), .err_push(ctl[0]), .err_pop(ctl[1]),
    .err_clear(ctl[2]), .out_push(ctl[3]), .out_pop(ctl[4]), .mask_wr(ctl[5]), .mask_wdata(mask_wdata),
    .mask_query(ctl[6]), .stb_query(ctl[7]), .resp_data_r(resp), .resp_valid_r(rvalid), .spoll_done(spoll_done),
    .spoll_byte_r(pbyte), .spoll_valid_r(pvalid), .srq(srq), .status_summary_byte(ssb),
    .request_enable_mask_r(mask), .error_queue_nonempty(eqn), .questionable_summary(qs),
    .standard_event_summary(ses), .operation_summary(os));
  sbsr_ctrl_model ctrl (.mclk(mclk), .rst_n(rst_n), .auto_en(auto_en), .srq(srq), .spoll_valid_r(pvalid),
    .spoll_byte_r(pbyte), .spoll_done(spoll_done), .poll_byte(poll_byte));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task strobe(input int b);
    @(posedge mclk);
    ctl[b] <= 1'b1;
    @(posedge mclk);
    ctl <= '0;
    #1;
  endtask
  task query(input int b, input logic [15:0] exp);
    strobe(b);
    chk(rvalid, 1'b1);
    chk(resp, exp);
  endtask
  task mask_w(input logic [7:0] v);
    @(posedge mclk);
    mask_wdata <= v;
    strobe(5);
  endtask
  task set_en(input int s, input logic [15:0] v);
    @(posedge mclk);
    sel <= sbsr_pkg::sbsr_set_type'(s);
    en_wdata <= v;
    strobe(8);
  endtask
  task pulse_ev(input int s, input logic [15:0] v);
    @(posedge mclk);
    ev[s] <= v;
    @(posedge mclk);
    ev[s] <= '0;
    #1;
  endtask
  // one poll takes a fixed five cycles through the controller model
  task poll();
    @(posedge mclk);
    auto_en <= 1'b1;
    @(posedge mclk);
    auto_en <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task wrap_up();
    $display("checked %0d, n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk(ssb, 8'h00);
    chk(mask, 8'h00);
    foreach (bitv[i]) begin
      mask_w(~bitv[i]);
      query(6, {8'h00, ~bitv[i]});
    end
    mask_w(8'h00);
    chk(mask, 8'h00);
    mask_w(8'h04);
    strobe(0);
    chk(ssb, 8'h44);
    chk(srq, 1'b1);
    query(7, 16'h0044);
    poll();
    chk(poll_byte, 8'h44);
    chk(srq, 1'b0);
    chk(ssb, 8'h44);
    strobe(0);
    chk(srq, 1'b1);
    strobe(1);
    chk(ssb, 8'h44);
    poll();
    strobe(2);
    chk(ssb, 8'h00);
    mask_w(8'h20);
    set_en(0, 16'h0001);
    pulse_ev(0, 16'h0001);
    chk(ssb, 8'h60);
    query(9, 16'h0001);
    chk(ssb, 8'h00);
    mask_w(8'h89);
    expv = 8'h40;
    for (int s = 1; s < 4; s++) begin
      set_en(s, 16'h8000);
      pulse_ev(s, 16'h8000);
      expv |= bitv[s-1];
      chk(ssb, expv);
    end
    strobe(11);
    chk(ssb, 8'h00);
    chk(mask, 8'h89);
    strobe(10);
    chk(mask, 8'h89);
    strobe(3);
    chk(ssb, 8'h10);
    strobe(4);
    chk(ssb, 8'h00);
    poll();
    chk(srq, 1'b0);
    mask_w(8'h10);
    strobe(3);
    chk(ssb, 8'h50);
    // a level rise without a fresh pulse raises the flag one cycle later
    @(posedge mclk);
    #1;
    chk(srq, 1'b1);
    wrap_up();
  end
endmodule
